// >>> rtl/pulse_dac_pkg.sv
// Package of register offsets, field positions and timing counts.
package pulse_dac_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] DUTY_A_ADDR      = 8'h0a;
    localparam logic [7:0] DUTY_B_ADDR      = 8'h0b;
    localparam logic [7:0] MISC_ADDR        = 8'h0c;
    localparam logic [7:0] DUTY_RESET       = 8'h00;
    // Field positions inside misc_control
    localparam int         RATE_SEL_A_BIT   = 3;
    localparam int         RATE_SEL_B_BIT   = 2;
    localparam int         BUS_SLOWDOWN_BIT = 1;
    // ==========================================================
    // Timing
    localparam int         CPU_PER_TICK     = 4;
    localparam int         SLOW_BUS_RATIO   = 16;
    localparam logic [1:0] TICK_DIV_LAST    = 2'h3;
    localparam logic [3:0] SLOW_DIV_LAST    = 4'hf;
    localparam logic [11:0] FAST_PERIOD_LAST = 12'h0ff;
    localparam logic [11:0] SLOW_PERIOD_LAST = 12'hfff;
endpackage

// >>> rtl/pulse_channel.sv
// One pulse length channel with double-buffered duty value.
`timescale 1ns/1ps
`default_nettype none
module pulse_channel
    import pulse_dac_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       hold,
    input  wire logic       counterClear,
    input  wire logic       rateSel,
    input  wire logic [7:0] dutyBuffer,
    output logic            pulseOut
);
    typedef struct packed {
        logic [11:0] position;
        logic [7:0]  activeDuty;
        logic        pulse;
    } chan_state_t;

    chan_state_t state;
    chan_state_t next_state;
    logic [7:0]  slice;
    logic [11:0] periodLast;

    // ==========================================================
    // Next state
    always_comb begin
        next_state = state;
        periodLast = rateSel ? SLOW_PERIOD_LAST : FAST_PERIOD_LAST;
        // Slow period scales 4096 ticks onto 256 slices
        slice = rateSel ? state.position[11:4] : state.position[7:0];
        if (counterClear) begin
            next_state.position = 12'h000;
        end else if (tick && !hold) begin
            if (state.position >= periodLast) begin
                next_state.position   = 12'h000;
                next_state.activeDuty = dutyBuffer;
            end else begin
                next_state.position = state.position + 12'h001;
            end
        end
        if (!hold) begin
            // Zero duty never compares high, 0xff leaves one slice low
            next_state.pulse = slice < state.activeDuty;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pulseOut = state.pulse;
endmodule
`default_nettype wire

// >>> rtl/dual_pulse_length_dac.sv
// Top of the dual pulse length D/A converter with its register port.
`timescale 1ns/1ps
`default_nettype none
module dual_pulse_length_dac
    import pulse_dac_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [7:0] address,
    input  wire logic [7:0] writeData,
    input  wire logic       writeStrobe,
    input  wire logic       readStrobe,
    output logic      [7:0] readData,
    input  wire logic       stopMode,
    input  wire logic       waitMode,
    input  wire logic       timerClear,
    output logic            timerOverflowFlag,
    output logic            busSlowdown,
    output logic            pulseOutA,
    output logic            pulseOutB
);
    typedef struct packed {
        logic [7:0]  dutyValueA;
        logic [7:0]  dutyValueB;
        logic        rateSelA;
        logic        rateSelB;
        logic        slowdown;
        logic [1:0]  tickDiv;
        logic [3:0]  slowDiv;
        logic [11:0] timerCount;
        logic        overflow;
        logic [7:0]  readData;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;
    logic       busEnable;
    logic       tick;
    logic       hold;

    // ==========================================================
    // Timing chain: bus enable, timer tick, free-running counter
    // WAIT is deliberately ignored here so waveforms keep going
    always_comb begin
        hold      = stopMode;
        // In slow mode only one bus cycle in sixteen is live
        busEnable = !state.slowdown || (state.slowDiv == SLOW_DIV_LAST);
        tick      = busEnable && (state.tickDiv == TICK_DIV_LAST) && !hold;
    end

    // ==========================================================
    // Next state, including the register port
    always_comb begin
        next_state          = state;
        next_state.readData = 8'h00;
        next_state.overflow = 1'b0;
        if (!hold) begin
            next_state.slowDiv = state.slowDiv + 4'h1;
            if (busEnable) begin
                next_state.tickDiv = state.tickDiv + 2'h1;
            end
        end
        if (timerClear) begin
            next_state.timerCount = 12'h000;
        end else if (tick) begin
            next_state.timerCount = state.timerCount + 12'h001;
            // Overflow every 4096 ticks; the channels keep their own period counters
            next_state.overflow   = (state.timerCount == SLOW_PERIOD_LAST);
        end
        if (writeStrobe) begin
            unique case (address)
                DUTY_A_ADDR: next_state.dutyValueA = writeData;
                DUTY_B_ADDR: next_state.dutyValueB = writeData;
                MISC_ADDR: begin
                    // Rate bits act immediately, software orders them
                    next_state.rateSelA = writeData[RATE_SEL_A_BIT];
                    next_state.rateSelB = writeData[RATE_SEL_B_BIT];
                    next_state.slowdown = writeData[BUS_SLOWDOWN_BIT];
                end
                default: ;
            endcase
        end
        if (stopMode) begin
            next_state.slowdown = 1'b0;
        end
        if (readStrobe) begin
            unique case (address)
                DUTY_A_ADDR: next_state.readData = state.dutyValueA;
                DUTY_B_ADDR: next_state.readData = state.dutyValueB;
                MISC_ADDR: begin
                    next_state.readData[RATE_SEL_A_BIT]   = state.rateSelA;
                    next_state.readData[RATE_SEL_B_BIT]   = state.rateSelB;
                    next_state.readData[BUS_SLOWDOWN_BIT] = state.slowdown;
                end
                default: next_state.readData = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // State register; reset clears duties and slowdown
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign readData          = state.readData;
    assign timerOverflowFlag = state.overflow;
    assign busSlowdown       = state.slowdown;

    // ==========================================================
    // Channels
    pulse_channel chanA (
        .core_clk     (core_clk),
        .rst          (rst),
        .tick         (tick),
        .hold         (hold),
        .counterClear (timerClear),
        .rateSel      (state.rateSelA),
        .dutyBuffer   (state.dutyValueA),
        .pulseOut     (pulseOutA)
    );

    pulse_channel chanB (
        .core_clk     (core_clk),
        .rst          (rst),
        .tick         (tick),
        .hold         (hold),
        .counterClear (timerClear),
        .rateSel      (state.rateSelB),
        .dutyBuffer   (state.dutyValueB),
        .pulseOut     (pulseOutB)
    );
endmodule
`default_nettype wire

// >>> test/dual_pulse_dac_checker.sv
// Port assertions for the dual pulse length converter.
`timescale 1ns/1ps
`default_nettype none
module dual_pulse_dac_checker
    import pulse_dac_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [7:0] address,
    input wire logic [7:0] writeData,
    input wire logic       writeStrobe,
    input wire logic       readStrobe,
    input wire logic [7:0] readData,
    input wire logic       stopMode,
    input wire logic       timerOverflowFlag,
    input wire logic       busSlowdown,
    input wire logic       pulseOutA,
    input wire logic       pulseOutB
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Write of duty A, a quiet cycle, then a read of it
    sequence s_writeReadA;
        writeStrobe && address == DUTY_A_ADDR ##1 !writeStrobe
        ##1 readStrobe && address == DUTY_A_ADDR;
    endsequence
    chk_read_back: assert property (s_writeReadA |=>
        readData == $past(writeData, 3)) else $error("duty readback");
    chk_read_idle: assert property (!readStrobe |=>
        readData == 8'h00) else $error("read data not idle");
    chk_unmapped_zero: assert property (
        readStrobe && address == 8'h00 |=> readData == 8'h00)
        else $error("unmapped read");
    chk_misc_spare: assert property (
        readStrobe && address == MISC_ADDR |=>
        readData[7:4] == 4'h0 && !readData[0]) else $error("misc spare");
    // Outputs hold once stop has been seen twice
    chk_stop_freeze: assert property (stopMode [*2] |=>
        $stable(pulseOutA) && $stable(pulseOutB)) else $error("no freeze");
    chk_stop_slow: assert property (stopMode |=> !busSlowdown)
        else $error("slowdown kept in stop");
    chk_slow_cause: assert property ($changed(busSlowdown) |->
        $past(writeStrobe && address == MISC_ADDR) || $past(stopMode))
        else $error("slowdown changed alone");
    chk_flag_pulse: assert property (
        timerOverflowFlag |=> !timerOverflowFlag) else $error("flag long");
endmodule
`default_nettype wire

// >>> test/pulse_load_model.sv
// Load model that integrates both pulse outputs like an RC filter.
`timescale 1ns/1ps
`default_nettype none
module pulse_load_model (
    input  wire logic        core_clk,
    input  wire logic        clear,
    input  wire logic        pulseOutA,
    input  wire logic        pulseOutB,
    output logic      [15:0] highA,
    output logic      [15:0] highB
);
    // High clock count stands in for the filtered average level
    always_ff @(posedge core_clk) begin
        highA <= clear ? 16'h0000 : highA + 16'(pulseOutA);
        highB <= clear ? 16'h0000 : highB + 16'(pulseOutB);
    end
endmodule
`default_nettype wire

// >>> test/tb_dual_pulse_length_dac.sv
// Bench for the dual pulse length converter: registers and waveforms.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_pulse_length_dac;
    import pulse_dac_pkg::*;
    logic        core_clk = 1'b0, rst = 1'b1, clear = 1'b1;
    logic        writeStrobe = 1'b0, readStrobe = 1'b0, stopMode = 1'b0;
    logic        waitMode = 1'b0, timerClear = 1'b0;
    logic [7:0]  address = 8'h00, writeData = 8'h00, readData;
    logic        timerOverflowFlag, busSlowdown, pulseOutA, pulseOutB;
    logic [15:0] highA, highB;
    int          failures = 0, checks_done = 0;
    // Rows: misc, duty A, duty B, window clocks, high A, high B
    logic [15:0] rows [4][6] = '{
        '{16'h00, 16'h80, 16'hff, 16'h0400, 16'h0200, 16'h03fc},
        '{16'h08, 16'h40, 16'h00, 16'h4000, 16'h1000, 16'h0000},
        '{16'h04, 16'h01, 16'h80, 16'h4000, 16'h0040, 16'h2000},
        '{16'h02, 16'h80, 16'h01, 16'h4000, 16'h2000, 16'h0040}};
    always #50 core_clk = ~core_clk;
    dual_pulse_length_dac dut (.core_clk, .rst, .address, .writeData,
        .writeStrobe, .readStrobe, .readData, .stopMode, .waitMode,
        .timerClear, .timerOverflowFlag, .busSlowdown, .pulseOutA,
        .pulseOutB);
    pulse_load_model load (.core_clk, .clear, .pulseOutA, .pulseOutB,
        .highA, .highB);
    // ==========================================================
    // Bus tasks; a gap cycle follows each strobe
    task automatic check(input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge core_clk);
        writeStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge core_clk);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge core_clk);
        readStrobe <= 1'b0;
        @(negedge core_clk);
        check(16'(readData), 16'(exp));
        // Back on a rising edge so the next drive is edge aligned
        @(posedge core_clk);
    endtask
    // Filtered level over a window of whole periods
    task automatic measure(input int w, input logic [15:0] ea, eb);
        clear <= 1'b0;
        repeat (w) @(posedge core_clk);
        clear <= 1'b1;
        @(negedge core_clk);
        check(highA, ea);
        check(highB, eb);
        @(posedge core_clk);
    endtask
    task automatic finish_test();
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard; the full run is near 10 ms
    initial begin
        #15ms;
        failures++;
        finish_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // Rate bits go first since they act at once
        for (int i = 0; i < 4; i++) begin
            waitMode <= (i == 0);
            wr(MISC_ADDR, rows[i][0][7:0]);
            wr(DUTY_B_ADDR, rows[i][2][7:0]);
            wr(DUTY_A_ADDR, rows[i][1][7:0]);
            rd(DUTY_A_ADDR, rows[i][1][7:0]);
            repeat (rows[i][3] + 4) @(posedge core_clk);
            measure(rows[i][3], rows[i][4], rows[i][5]);
        end
        wr(8'h00, 8'h55);
        rd(8'h00, 8'h00);
        rd(DUTY_A_ADDR, 8'h80); // Unmapped write left duty A alone
        wr(MISC_ADDR, 8'hff);
        rd(MISC_ADDR, 8'h0e);
        stopMode <= 1'b1;
        repeat (20) @(posedge core_clk);
        stopMode <= 1'b0;
        rd(MISC_ADDR, 8'h0c);
        // Fast rates with slowdown on, so reset has something to clear
        wr(MISC_ADDR, 8'h02);
        // Clearing the timer restarts both periods at slice zero
        timerClear <= 1'b1;
        @(posedge core_clk);
        timerClear <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        check(16'(pulseOutB), 16'h0001);
        repeat (99) @(posedge core_clk);
        @(negedge core_clk);
        check(16'(pulseOutB), 16'h0000);
        check(16'(pulseOutA), 16'h0001);
        @(posedge core_clk);
        rst <= 1'b1;
        @(negedge core_clk);
        check(16'(pulseOutA), 16'h0000);
        check(16'(busSlowdown), 16'h0000);
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(DUTY_A_ADDR, DUTY_RESET);
        rd(DUTY_B_ADDR, DUTY_RESET);
        measure(1024, 16'h0000, 16'h0000);
        finish_test();
    end
endmodule
bind dual_pulse_length_dac dual_pulse_dac_checker chk (.core_clk, .rst,
    .address, .writeData, .writeStrobe, .readStrobe, .readData, .stopMode,
    .timerOverflowFlag, .busSlowdown, .pulseOutA, .pulseOutB);
`default_nettype wire
